//--- bench/fm_dac_model.sv
`default_nettype none

module fm_dac_model
#(
  parameter int W = 16
)
(
  // Converter pins
  input  wire logic         dac_clock_i,
  input  wire logic         serial_i,
  input  wire logic         hold_a_i,
  input  wire logic         hold_b_i,
  // Held channel words
  output logic      [W-1:0] left_o,
  output logic      [W-1:0] right_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W-1:0] shift;
  logic [W-1:0] next_shift;

  // Bits arrive LSB first, so shift in at the top
  assign next_shift = {serial_i, shift[W-1:1]};

  // Sample mid bit, where the stream is settled
  always_ff @(posedge dac_clock_i)
  begin
    shift <= next_shift;
    if (hold_a_i)
      left_o <= next_shift;
    if (hold_b_i)
      right_o <= next_shift;
  end
endmodule : fm_dac_model

`default_nettype wire

//--- bench/fm_synth_host_port_bench.sv
`default_nettype none

module fm_synth_host_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, ic_n = 1, cs_n = 1, wr_n = 1, rd_n = 1;
  logic sel = 0, oe, irq_v, irq_oe, ext_a, ext_b, dclk, ser, sa, sb;
  logic [7:0] host_d = 8'h00, bus, dout;
  logic [15:0] left_s = 16'h0000, right_s = 16'h0000, rnd = 16'hAA54;
  logic [15:0] left_m, right_m;
  int miscompares = 0, cmp_count = 0, ext_exp = 0;

  always #50 clk_i = ~clk_i;
  // Floating bus reads as whatever the host last left on it
  assign bus = oe ? dout : host_d;

  fm_synth_host_port #(.SAMPLE_W(16), .PRESCALE(2)) fm_synth_host_port_inst
  (
    .clk_i(clk_i), .rst_i(rst_i), .initial_clear_n_i(ic_n), .cs_n_i(cs_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .addr_data_sel_i(sel), .data_i(bus),
    .data_o(dout), .data_oe_o(oe), .irq_n_o(irq_v), .irq_n_oe_o(irq_oe),
    .ext_control_out_a_o(ext_a), .ext_control_out_b_o(ext_b),
    .left_sample_i(left_s), .right_sample_i(right_s), .dac_clock_o(dclk),
    .serial_data_o(ser), .dac_hold_strobe_a_o(sa), .dac_hold_strobe_b_o(sb)
  );
  fm_dac_model #(.W(16)) fm_dac_model_inst
  (
    .dac_clock_i(dclk), .serial_i(ser), .hold_a_i(sa), .hold_b_i(sb),
    .left_o(left_m), .right_o(right_m)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Inputs move a fixed delay after the rising edge
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #10;
  endtask : step

  // One host write; idle bus carries noise
  task automatic bus_wr(input logic c, input logic s, input logic [7:0] d);
    step();
    cs_n = c;
    wr_n = 0;
    sel = s;
    host_d = d;
    step();
    cs_n = 1;
    wr_n = 1;
    rnd = lfsr(rnd);
    host_d = rnd[7:0];
  endtask : bus_wr

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    bus_wr(0, 0, a);
    bus_wr(0, 1, d);
  endtask : reg_wr

  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 40 && irq_oe !== lvl; i++)
      step();
    chk("irq", {15'h0, lvl}, {15'h0, irq_oe});
    if (irq_oe !== lvl)
      stop_test();
  endtask : wait_irq

  // Status read: refused without select, then driven with it
  task automatic read_st(input logic [7:0] e);
    step();
    rd_n = 0;
    step();
    chk("oe_nocs", 16'h0000, {15'h0, oe});
    cs_n = 0;
    step();
    chk("oe", 16'h0001, {15'h0, oe});
    chk("status", {8'h0, e}, {8'h0, dout});
    cs_n = 1;
    rd_n = 1;
  endtask : read_st

  task automatic timer(input logic [7:0] go, clr, st);
    reg_wr(8'h23, go);
    wait_irq(1);
    read_st(st);
    // Stop first: a carry in the clear cycle would keep the flag
    reg_wr(8'h23, 8'h00);
    reg_wr(8'h23, clr);
    wait_irq(0);
  endtask : timer

  initial
  begin
    step(16);
    chk("reset_outs", 16'h0000,
        {10'h000, ext_a, ext_b, irq_oe, ser, sa, sb});
    rst_i = 0;
    ext_exp = 3;
    reg_wr(8'h24, 8'h03);
    step(4);
    chk("ext", ext_exp[15:0], {14'h0000, ext_b, ext_a});
    bus_wr(1, 1, 8'h00);
    step(4);
    chk("ext_nocs", ext_exp[15:0], {14'h0000, ext_b, ext_a});
    reg_wr(8'h20, 8'hFF);
    reg_wr(8'h21, 8'h03);
    timer(8'h05, 8'h10, 8'h01);
    reg_wr(8'h22, 8'hFF);
    timer(8'h0A, 8'h20, 8'h02);
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      left_s = rnd;
      rnd = lfsr(rnd);
      right_s = rnd;
      step(200);
      chk("left", left_s, left_m);
      chk("right", right_s, right_m);
    end
    ic_n = 0;
    ext_exp = 0;
    step(2);
    chk("ext_ic", ext_exp[15:0], {14'h0000, ext_b, ext_a});
    ic_n = 1;
    ext_exp = 1;
    reg_wr(8'h24, 8'h01);
    step(4);
    chk("ext_after", ext_exp[15:0], {14'h0000, ext_b, ext_a});
    stop_test();
  end
endmodule : fm_synth_host_port_bench

`default_nettype wire

//--- bench/fm_synth_host_port_chk.sv
`default_nettype none

module fm_synth_host_port_chk
(
  // Clock, resets and host strobes
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic initial_clear_n_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  // Device outputs
  input wire logic data_oe_o,
  input wire logic irq_n_o,
  input wire logic irq_n_oe_o,
  input wire logic ext_control_out_a_o,
  input wire logic ext_control_out_b_o,
  input wire logic dac_clock_o,
  input wire logic serial_data_o,
  input wire logic dac_hold_strobe_a_o,
  input wire logic dac_hold_strobe_b_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !initial_clear_n_i);

  // Pins that move only on converter clock falls
  logic [5:0] slow;
  assign slow = {irq_n_oe_o, ext_control_out_a_o, ext_control_out_b_o,
                 serial_data_o, dac_hold_strobe_a_o, dac_hold_strobe_b_o};

  // Bus drive and clear behaviour
  AST_OE_READ: assert property (
    data_oe_o == (!cs_n_i && !rd_n_i && wr_n_i))
    else $error("bus drive does not follow read strobe");
  AST_NO_CS: assert property (cs_n_i |-> !data_oe_o)
    else $error("bus driven without chip select");
  AST_CLEAR: assert property (@(posedge clk_i) disable iff (1'b0)
    (rst_i || !initial_clear_n_i) |=> (slow == 6'h00) && !dac_clock_o)
    else $error("outputs not cleared");
  // Converter timing and interrupt pin level
  AST_DCLK: assert property (1'b1 |=>
    dac_clock_o != $past(dac_clock_o))
    else $error("converter clock not half rate");
  AST_FALL_ONLY: assert property (!dac_clock_o |=> $stable(slow))
    else $error("output moved off a falling edge");
  AST_IRQ_LOW: assert property (irq_n_o == 1'b0)
    else $error("interrupt pin value not low");
  AST_STB_W: assert property ($rose(dac_hold_strobe_a_o) |=>
    dac_hold_strobe_a_o ##1 !dac_hold_strobe_a_o)
    else $error("hold strobe width wrong");
  AST_STB_AB: assert property ($rose(dac_hold_strobe_a_o) |->
    ##32 $rose(dac_hold_strobe_b_o))
    else $error("right strobe misplaced");
  AST_STB_BA: assert property ($rose(dac_hold_strobe_b_o) |->
    ##32 $rose(dac_hold_strobe_a_o))
    else $error("left strobe misplaced");

  // Main scenarios reached
  cover property ($rose(irq_n_oe_o));
  cover property ($rose(dac_hold_strobe_b_o));
  cover property (data_oe_o);
endmodule : fm_synth_host_port_chk

bind fm_synth_host_port fm_synth_host_port_chk chk_inst
(
  .clk_i(clk_i), .rst_i(rst_i), .initial_clear_n_i(initial_clear_n_i),
  .cs_n_i(cs_n_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i),
  .data_oe_o(data_oe_o), .irq_n_o(irq_n_o), .irq_n_oe_o(irq_n_oe_o),
  .ext_control_out_a_o(ext_control_out_a_o),
  .ext_control_out_b_o(ext_control_out_b_o), .dac_clock_o(dac_clock_o),
  .serial_data_o(serial_data_o),
  .dac_hold_strobe_a_o(dac_hold_strobe_a_o),
  .dac_hold_strobe_b_o(dac_hold_strobe_b_o)
);

`default_nettype wire

//--- core/fm_synth_host_port.sv
`include "fm_synth_host_port_regs.svh"
`default_nettype none

module fm_synth_host_port
  import fm_synth_host_port_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int PRESCALE = `TIMER_PRESCALE
)
(
  // Master clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                initial_clear_n_i,
  // Host bus
  input  wire logic                cs_n_i,
  input  wire logic                wr_n_i,
  input  wire logic                rd_n_i,
  input  wire logic                addr_data_sel_i,
  input  wire logic [7:0]          data_i,
  output logic      [7:0]          data_o,
  output logic                     data_oe_o,
  // Open-drain interrupt
  output logic                     irq_n_o,
  output logic                     irq_n_oe_o,
  // External control outputs
  output logic                     ext_control_out_a_o,
  output logic                     ext_control_out_b_o,
  // Tone samples from the synthesis core
  input  wire logic [SAMPLE_W-1:0] left_sample_i,
  input  wire logic [SAMPLE_W-1:0] right_sample_i,
  // Converter side
  output logic                     dac_clock_o,
  output logic                     serial_data_o,
  output logic                     dac_hold_strobe_a_o,
  output logic                     dac_hold_strobe_b_o
);

  localparam int FRAME_BITS = 2 * SAMPLE_W;
  localparam int FRAME_W    = $clog2(FRAME_BITS);
  localparam int PRE_W      = $clog2(PRESCALE + 1);
  localparam logic [FRAME_W-1:0] LAST_LEFT =
    FRAME_W'(SAMPLE_W - 1);
  localparam logic [FRAME_W-1:0] LAST_RIGHT =
    FRAME_W'(FRAME_BITS - 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRESCALE - 1);

  // Either reset source clears the whole block
  logic                clear;
  logic                phase;
  logic                fall;
  access_type          access;
  logic [7:0]          addr;
  logic [9:0]          timer_a_load;
  logic [7:0]          timer_b_load;
  logic [7:0]          timer_ctrl;
  logic [1:0]          ext_ctrl;
  logic [9:0]          count_a;
  logic [7:0]          count_b;
  logic [PRE_W-1:0]    prescale;
  logic                tick;
  logic                over_a;
  logic                over_b;
  logic                flag_a;
  logic                flag_b;
  logic                clr_a;
  logic                clr_b;
  logic [7:0]          status;
  logic [FRAME_W-1:0]  bit_pos;
  logic [FRAME_BITS-1:0] shift;

  // Both clears are level inputs taken on the clock; a glitch on the
  // pin clear that meets an edge resets everything, there is no filter
  assign clear = rst_i | ~initial_clear_n_i;    // see R6 R15

  // Internal clock is half the master clock; fall marks its falling edge.
  // Phase starts low after clear, so the converter first sees a rise
  // and never a stray fall
  always_ff @(posedge clk_i)
  begin
    if (clear)
      phase <= 1'b0;
    else
      phase <= ~phase;    // see R12
  end

  assign fall        = phase;
  assign dac_clock_o = phase;    // see R13

  // Decode the strobes; nothing happens without chip select.
  // Write wins when both strobes are low, which keeps the bus undriven
  always_comb
  begin
    access = ACC_IDLE;
    if (!cs_n_i)    // see R3 R15
    begin
      if (!wr_n_i && !addr_data_sel_i)
        access = ACC_ADDR;    // see R2
      else if (!wr_n_i)
        access = ACC_DATA;    // see R2 R4
      else if (!rd_n_i)
        access = ACC_READ;
    end
  end

  // Address latch; a held strobe rewrites the same value harmlessly
  always_ff @(posedge clk_i)
  begin
    if (clear)
      addr <= `ADDR_RST;
    else if (access == ACC_ADDR)
      addr <= data_i;    // see R1 R2
  end

  // Register writes; clear bits of timer control act once but are stored in timer_ctrl like the rest
  always_ff @(posedge clk_i)
  begin
    if (clear)
    begin
      timer_a_load <= `TIMER_A_RST;
      timer_b_load <= `TIMER_B_RST;
      timer_ctrl   <= `TIMER_CTRL_RST;
      ext_ctrl     <= `EXT_CTRL_RST;
    end
    else if (access == ACC_DATA)    // see R4
    begin
      if (addr == `TIMER_A_HI_ADDR)
        timer_a_load[9:2] <= data_i;
      else if (addr == `TIMER_A_LO_ADDR)
        timer_a_load[1:0] <= data_i[1:0];
      else if (addr == `TIMER_B_ADDR)
        timer_b_load <= data_i;
      else if (addr == `TIMER_CTRL_ADDR)
        timer_ctrl <= data_i;
      else if (addr == `EXT_CTRL_ADDR)
        ext_ctrl <= data_i[1:0];
    end
  end

  // One-cycle clear requests from a timer control write
  assign clr_a = (access == ACC_DATA) && (addr == `TIMER_CTRL_ADDR) &&
                 data_i[`TCTRL_CLR_A];
  assign clr_b = (access == ACC_DATA) && (addr == `TIMER_CTRL_ADDR) &&
                 data_i[`TCTRL_CLR_B];

  // Shared prescaler paced by the internal clock. One counter serves both
  // timers, which saves area but lets the first tick after a start come
  // early by up to one prescaler period
  always_ff @(posedge clk_i)
  begin
    if (clear)
      prescale <= '0;
    else if (fall)
      prescale <= (prescale == PRE_LAST) ? '0 : prescale + PRE_W'(1);
  end

  assign tick   = fall && (prescale == PRE_LAST);
  assign over_a = tick && timer_ctrl[`TCTRL_RUN_A] && (&count_a);
  assign over_b = tick && timer_ctrl[`TCTRL_RUN_B] && (&count_b);

  // Timer A counts up from its load value and reloads on carry out.
  // A load of all ones overflows on every tick, the fastest rate
  always_ff @(posedge clk_i)
  begin
    if (clear)
      count_a <= `TIMER_A_RST;
    else if (!timer_ctrl[`TCTRL_RUN_A])
      count_a <= timer_a_load;
    else if (over_a)
      count_a <= timer_a_load;
    else if (tick)
      count_a <= count_a + 10'h001;
  end

  // Timer B works the same way on eight bits
  always_ff @(posedge clk_i)
  begin
    if (clear)
      count_b <= `TIMER_B_RST;
    else if (!timer_ctrl[`TCTRL_RUN_B])
      count_b <= timer_b_load;
    else if (over_b)
      count_b <= timer_b_load;
    else if (tick)
      count_b <= count_b + 8'h01;
  end

  // Sticky overflow flags; a carry in the clear cycle is kept.
  // Software should stop a running timer before clearing its flag,
  // otherwise a carry in that same cycle leaves the flag set
  always_ff @(posedge clk_i)
  begin
    if (clear)
    begin
      flag_a <= 1'b0;
      flag_b <= 1'b0;
    end
    else
    begin
      if (over_a && timer_ctrl[`TCTRL_IRQ_EN_A])
        flag_a <= 1'b1;    // see R7
      else if (clr_a)
        flag_a <= 1'b0;
      if (over_b && timer_ctrl[`TCTRL_IRQ_EN_B])
        flag_b <= 1'b1;    // see R7
      else if (clr_b)
        flag_b <= 1'b0;
    end
  end

  // Status tells the host which timer asked for service
  always_comb
  begin
    status               = 8'h00;
    status[`STAT_FLAG_A] = flag_a;    // see R8
    status[`STAT_FLAG_B] = flag_b;
  end

  // Read data is registered; a read in the first strobe cycle shows
  // the status of the cycle before, which the host access time covers
  always_ff @(posedge clk_i)
  begin
    if (clear)
      data_o <= 8'h00;
    else
      data_o <= status;    // see R5
  end

  // Bus is driven only during a selected read, otherwise it floats
  assign data_oe_o = (access == ACC_READ);    // see R1 R5

  // Interrupt and control pins follow their sources on the falling edge.
  // Registering them keeps the pins glitch free between falls, at the
  // cost of up to one internal clock of delay after a flag sets
  always_ff @(posedge clk_i)
  begin
    if (clear)
    begin
      irq_n_oe_o          <= 1'b0;
      ext_control_out_a_o <= 1'b0;    // see R9
      ext_control_out_b_o <= 1'b0;    // see R9
    end
    else if (fall)    // see R14
    begin
      irq_n_oe_o          <= flag_a | flag_b;    // see R7 R15
      ext_control_out_a_o <= ext_ctrl[`EXT_CTRL_A];
      ext_control_out_b_o <= ext_ctrl[`EXT_CTRL_B];
    end
  end

  // Open drain only ever pulls low
  assign irq_n_o = 1'b0;

  // Frame bit position; left word first, then right.
  // The converter clock runs free, so frames follow with no gap
  always_ff @(posedge clk_i)
  begin
    if (clear)
      bit_pos <= '0;
    else if (fall)
      bit_pos <= (bit_pos == LAST_RIGHT) ? '0 : bit_pos + FRAME_W'(1);
  end

  // Samples are caught at frame start so a mid-frame change cannot tear
  always_ff @(posedge clk_i)
  begin
    if (clear)
      shift <= '0;
    else if (fall && bit_pos == '0)
      shift <= {right_sample_i, left_sample_i};    // see R10
    else if (fall)
      shift <= {1'b0, shift[FRAME_BITS-1:1]};
  end

  // Serial bit and hold strobes, least significant bit first.
  // Bit 0 of the left word comes straight from the input because the
  // shift register is loaded on that very edge
  always_ff @(posedge clk_i)
  begin
    if (clear)
    begin
      serial_data_o       <= 1'b0;
      dac_hold_strobe_a_o <= 1'b0;
      dac_hold_strobe_b_o <= 1'b0;
    end
    else if (fall)    // see R14
    begin
      serial_data_o       <= (bit_pos == '0) ? left_sample_i[0]
                                             : shift[1];    // see R10
      dac_hold_strobe_a_o <= (bit_pos == LAST_LEFT);    // see R11
      dac_hold_strobe_b_o <= (bit_pos == LAST_RIGHT);    // see R11
    end
  end

endmodule : fm_synth_host_port

`default_nettype wire

//--- core/fm_synth_host_port_pkg.sv
`default_nettype none

package fm_synth_host_port_pkg;

  // Kind of host access seen in a cycle
  typedef enum logic [1:0]
  {
    ACC_IDLE = 2'b00,
    ACC_ADDR = 2'b01,
    ACC_DATA = 2'b10,
    ACC_READ = 2'b11
  } access_type;

endpackage : fm_synth_host_port_pkg

`default_nettype wire

//--- core/fm_synth_host_port_regs.svh
// How it works
// R1: One 8-bit two-way bus carries both addresses and data; it floats unless read data is driven.
// R2: With addr_data_sel low the bus holds an address, with it high it holds data.
// R3: Select, write and read strobes do nothing unless chip select is low.
// R4: While write and chip select are low the bus value is written to the addressed register.
// R5: While read and chip select are low the device drives its status onto the bus.
// R6: A low initial clear returns every register and all circuit state to its start value.
// R7: An overflow of either of the two timers pulls the open-drain interrupt low.
// R8: After an interrupt the host reads the status to learn which timer caused it.
// R9: Both external control outputs are low while the device is cleared.
// R10: The left and right tone samples leave as one serial bit stream to the converter.
// R11: Two hold strobes let the converter catch the serial word and hold each channel.
// R12: The master clock is halved to make the internal operating clock.
// R13: The converter clock runs at the internal clock rate.
// R14: Interrupt, control outputs, serial data and strobes change only as the converter clock falls.
// R15: Chip select, write, read and initial clear are active low, as is the interrupt.
`ifndef FM_SYNTH_HOST_PORT_REGS_SVH
`define FM_SYNTH_HOST_PORT_REGS_SVH

// Internal register addresses
`define TIMER_A_HI_ADDR  8'h20
`define TIMER_A_LO_ADDR  8'h21
`define TIMER_B_ADDR     8'h22
`define TIMER_CTRL_ADDR  8'h23
`define EXT_CTRL_ADDR    8'h24

// Timer control fields
`define TCTRL_RUN_A      0
`define TCTRL_RUN_B      1
`define TCTRL_IRQ_EN_A   2
`define TCTRL_IRQ_EN_B   3
`define TCTRL_CLR_A      4
`define TCTRL_CLR_B      5

// Control output fields
`define EXT_CTRL_A       0
`define EXT_CTRL_B       1

// Status fields
`define STAT_FLAG_A      0
`define STAT_FLAG_B      1

// Reset values
`define TIMER_A_RST      10'h000
`define TIMER_B_RST      8'h00
`define TIMER_CTRL_RST   8'h00
`define EXT_CTRL_RST     2'h0
`define ADDR_RST         8'h00

// Converter clock cycles between timer ticks
`define TIMER_PRESCALE   64

`endif
